// [rtl/adc_ctrl_pkg.sv]
// Shared constants for the converter sequence, timing and compare control.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz bus clock.
package adc_ctrl_pkg;

  localparam int NUM_CONV = 12;
  localparam int RES_W    = 12;
  localparam int CNT_W    = 4;
  localparam int PRS_W    = 5;
  localparam int DIV_W    = 6;
  localparam int SMP_W    = 5;

  // Byte addresses of the register map.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_TIMING    = 8'h04;
  localparam logic [7:0] OFS_CMP_EN    = 8'h08;
  localparam logic [7:0] OFS_CMP_SENSE = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_FLAGS     = 8'h14;
  localparam logic [1:0] RESULT_PAGE   = 2'h1;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_FIFO  = 1;
  localparam int CTRL_SCAN  = 2;
  localparam int CTRL_FRZ   = 3;
  localparam int CTRL_LEN   = 8;
  localparam logic [15:0] CTRL_MASK  = 16'h0F1E;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Timing control fields.
  localparam int TIM_SMP = 5;
  localparam int TIM_PRS = 0;
  localparam logic [7:0] TIMING_RESET = 8'h00;

  // Status register fields.
  localparam int STAT_BUSY = 4;
  localparam int STAT_HALT = 5;

  localparam logic [1:0] FRZ_RUN    = 2'h0;
  localparam logic [1:0] FRZ_FINISH = 2'h2;
  localparam logic [1:0] FRZ_NOW    = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sample phase length in conversion clock cycles, by select code.
  localparam logic [SMP_W-1:0] SAMPLE_LEN [8] = '{
    5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h10, 5'h14, 5'h18
  };

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;

endpackage : adc_ctrl_pkg

// [rtl/conv_ctl_if.sv]
// Control carrier between the sequencer and its divider and counter.
// Assumes all three parties run on the same bus clock.
`timescale 1ns/1ps
interface conv_ctl_if;
  import adc_ctrl_pkg::*;
  logic [PRS_W-1:0] divider_value;
  logic             run;
  logic             restart;
  logic             tick;
  logic             count_clear;
  logic             count_step;
  logic [CNT_W-1:0] count;

  modport seq (output divider_value, run, restart, count_clear, count_step,
               input tick, count);
  modport divider (input divider_value, run, restart, output tick);
  modport counter (input count_clear, count_step, output count);
endinterface : conv_ctl_if

// [rtl/conv_clk_div.sv]
// Conversion clock enable: one tick per conversion clock period.
// Assumes restart is pulsed whenever the divider value changes.
`timescale 1ns/1ps
module conv_clk_div
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  conv_ctl_if.divider ctl
);

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] gap_cnt;
  wire  [DIV_W-1:0] div_last = {ctl.divider_value, 1'b1};

  always_ff @(posedge aclk) begin
    if (!aresetn || ctl.restart) begin
      div_cnt <= '0;
    end else if (ctl.run) begin
      div_cnt <= (div_cnt == div_last) ? '0 : div_cnt + 1'b1;
    end
  end

  assign ctl.tick = ctl.run && (div_cnt == div_last);

  // Run cycles since the last tick, kept apart from the divider itself.
  always_ff @(posedge aclk) begin
    if (!aresetn || ctl.restart || ctl.tick) begin
      gap_cnt <= '0;
    end else if (ctl.run) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  AST_TICK_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.tick |-> gap_cnt == div_last)
    else $error("Conversion tick period does not match the divider value.");

endmodule : conv_clk_div

// [rtl/conv_counter.sv]
// Conversion counter that selects the result register being filled.
// Assumes clear and step come from the sequencer on the same clock.
`timescale 1ns/1ps
module conv_counter
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  conv_ctl_if.counter ctl
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge aclk) begin
    if (!aresetn || ctl.count_clear) begin
      count <= '0;
    end else if (ctl.count_step) begin
      count <= count + 1'b1;
    end
  end

  assign ctl.count = count;

  AST_CNT_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.count_step && !ctl.count_clear && (count == 4'hF) |=> count == 4'h0)
    else $error("Conversion counter failed to wrap to zero.");

endmodule : conv_counter

// [rtl/adc_sequence_timing_compare.sv]
// Converter sequencer: timing, conversion counter, compare and freeze control.
// Assumes an analog sample/SAR machine on the bus clock and an AXI4-Lite master.
//
// Function
// - Freeze select 10 finishes the running conversion then halts; 11 halts at once.
// - Writing timing control or compare enable aborts the running sequence.
// - Sample time select picks 4,6,8,10,12,16,20 or 24 conversion clocks.
// - Conversion clock is bus clock over two times divider value plus two.
// - Read-only conversion counter names the result register being filled now.
// - Without fifo mode the counter clears at sequence start and end.
// - In fifo mode the counter carries across sequences; it always wraps.
// - Abort or a new start clears the counter even in fifo mode.
// - Twelve compare enable bits select compare by position in the sequence.
// - Compare sense bit n selects higher-than or lower-or-equal for conversion n.
// - A successful enabled compare sets match flag n in the flag status register.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module adc_sequence_timing_compare
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]       awaddr,
  input  wire logic [2:0]       awprot,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]       araddr,
  input  wire logic [2:0]       arprot,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  // Debug.
  input  wire logic             debug_freeze,
  // Analog machine.
  output logic                  sample_enable,
  output logic                  convert_start,
  input  wire logic             result_valid,
  input  wire logic [RES_W-1:0] result_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic [15:0]      ctrl;
  logic [7:0]       timing;
  logic [11:0]      cmp_en;
  logic [11:0]      cmp_sense;
  logic [11:0]      flags;
  logic [RES_W-1:0] results [NUM_CONV];

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
               strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : merge16

  assign awready = !aw_held;
  assign wready  = !w_held;

  wire       wr_fire    = aw_held && w_held && !bvalid;
  wire [3:0] wr_idx     = aw_addr[5:2];
  wire       wr_ctrl    = wr_fire && (aw_addr == OFS_CTRL);
  wire       wr_timing  = wr_fire && (aw_addr == OFS_TIMING);
  wire       wr_cmp_en  = wr_fire && (aw_addr == OFS_CMP_EN);
  wire       wr_sense   = wr_fire && (aw_addr == OFS_CMP_SENSE);
  wire       wr_flags   = wr_fire && (aw_addr == OFS_FLAGS);
  wire       wr_res     = wr_fire && (aw_addr[7:6] == RESULT_PAGE) &&
                          (aw_addr[1:0] == 2'h0) && (wr_idx < 4'(NUM_CONV));
  wire       wr_status  = wr_fire && (aw_addr == OFS_STATUS);
  wire       wr_hit     = wr_ctrl || wr_timing || wr_cmp_en || wr_sense ||
                          wr_flags || wr_res || wr_status;
  wire       start_req  = wr_ctrl && w_strb[0] && w_data[CTRL_START];
  wire       abort_req  = wr_timing || wr_cmp_en;
  wire [15:0] wr_merged = merge16(16'h0000, w_data[15:0], w_strb[1:0]);
  wire [11:0] flag_clr  = wr_flags ? wr_merged[11:0] : 12'h000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  conv_ctl_if ctl ();

  conv_state_t      state;
  conv_state_t      next_state;
  logic [SMP_W-1:0] sample_cnt;
  logic [CNT_W-1:0] seq_pos;

  wire [1:0]       frz_sel   = ctrl[CTRL_FRZ+1:CTRL_FRZ];
  wire             fifo_mode = ctrl[CTRL_FIFO];
  wire             scan_mode = ctrl[CTRL_SCAN];
  wire [CNT_W-1:0] seq_last  = ctrl[CTRL_LEN+3:CTRL_LEN];
  wire [2:0]       smp_sel   = timing[TIM_SMP+2:TIM_SMP];
  wire [SMP_W-1:0] smp_last  = SAMPLE_LEN[smp_sel] - 1'b1;
  wire             busy      = !state[0];

  // Code 01 is reserved and behaves like 00, so only the high bit arms a halt.
  wire halt_now  = debug_freeze && (frz_sel == FRZ_NOW);
  wire halt_edge = debug_freeze && (frz_sel == FRZ_FINISH) &&
                   (state == ST_SAMPLE) && (sample_cnt == '0);
  wire stall     = halt_now || halt_edge;

  wire conv_done = (state == ST_CONVERT) && result_valid;
  wire seq_end   = conv_done && (seq_pos == seq_last);
  wire smp_done  = (state == ST_SAMPLE) && ctl.tick && (sample_cnt == smp_last);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:    next_state = ST_IDLE;
      ST_SAMPLE:  if (smp_done) next_state = ST_CONVERT;
      ST_CONVERT: begin
        if (conv_done) begin
          next_state = (seq_end && !scan_mode) ? ST_IDLE : ST_SAMPLE;
        end
      end
    endcase
    if (abort_req) begin
      next_state = ST_IDLE;
    end else if (start_req) begin
      next_state = ST_SAMPLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state         <= ST_IDLE;
      sample_cnt    <= '0;
      seq_pos       <= '0;
      convert_start <= 1'b0;
    end else begin
      state         <= next_state;
      convert_start <= smp_done && !abort_req && !start_req;
      if (next_state != ST_SAMPLE || state != ST_SAMPLE) begin
        sample_cnt <= '0;
      end else if (ctl.tick) begin
        sample_cnt <= sample_cnt + 1'b1;
      end
      if (abort_req || start_req || seq_end) begin
        seq_pos <= '0;
      end else if (conv_done) begin
        seq_pos <= seq_pos + 1'b1;
      end
    end
  end

  assign sample_enable = (state == ST_SAMPLE);

  // Divider only runs through the sample phase; the SAR paces itself.
  assign ctl.divider_value = timing[TIM_PRS+PRS_W-1:TIM_PRS];
  assign ctl.run           = (state == ST_SAMPLE) && !stall;
  assign ctl.restart       = abort_req || start_req || (state != ST_SAMPLE);
  assign ctl.count_clear   = abort_req || start_req || (seq_end && !fifo_mode);
  assign ctl.count_step    = conv_done;

  conv_clk_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (ctl)
  );

  conv_counter u_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (ctl)
  );

  wire [CNT_W-1:0] cnt = ctl.count;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and result storage.

  // The threshold lives in the result register of the same position, so a
  // compared conversion must not overwrite it.
  wire             pos_ok   = seq_pos < 4'(NUM_CONV);
  wire [3:0]       pos_idx  = pos_ok ? seq_pos : 4'h0;
  wire             cnt_ok   = cnt < 4'(NUM_CONV);
  wire [3:0]       cnt_idx  = cnt_ok ? cnt : 4'h0;
  wire [RES_W-1:0] thresh   = results[pos_idx];
  wire             cmp_act  = conv_done && pos_ok && cmp_en[pos_idx];
  wire             cmp_hit  = cmp_sense[pos_idx] ? (result_data > thresh) :
                                                   (result_data <= thresh);
  wire [11:0]      flag_set = (cmp_act && cmp_hit) ? (12'h001 << pos_idx) : 12'h000;
  wire             store    = conv_done && !cmp_act && cnt_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= CTRL_RESET;
      timing    <= TIMING_RESET;
      cmp_en    <= 12'h000;
      cmp_sense <= 12'h000;
      flags     <= 12'h000;
      for (int i = 0; i < NUM_CONV; i++) begin
        results[i] <= '0;
      end
    end else begin
      if (wr_ctrl) ctrl <= merge16(ctrl, w_data[15:0], w_strb[1:0]) & CTRL_MASK;
      if (wr_timing && w_strb[0]) timing <= w_data[7:0];
      if (wr_cmp_en) cmp_en <= 12'(merge16({4'h0, cmp_en}, w_data[15:0], w_strb[1:0]));
      if (wr_sense) cmp_sense <= 12'(merge16({4'h0, cmp_sense}, w_data[15:0], w_strb[1:0]));
      // A match arriving with its own clear is kept.
      flags <= (flags & ~flag_clr) | flag_set;
      if (wr_res) begin
        results[wr_idx] <= RES_W'(merge16({4'h0, results[wr_idx]},
                                          w_data[15:0], w_strb[1:0]));
      end
      if (store) results[cnt_idx] <= result_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  wire [3:0]  rd_idx  = araddr[5:2];
  wire        rd_res  = (araddr[7:6] == RESULT_PAGE) && (araddr[1:0] == 2'h0) &&
                        (rd_idx < 4'(NUM_CONV));
  wire [31:0] status  = {26'h0, stall && busy, busy, cnt};
  wire        rd_hit  = rd_res || (araddr == OFS_CTRL) || (araddr == OFS_TIMING) ||
                        (araddr == OFS_CMP_EN) || (araddr == OFS_CMP_SENSE) ||
                        (araddr == OFS_STATUS) || (araddr == OFS_FLAGS);
  wire [31:0] rd_mux  =
      (araddr == OFS_CTRL)      ? {16'h0, ctrl}          :
      (araddr == OFS_TIMING)    ? {24'h0, timing}        :
      (araddr == OFS_CMP_EN)    ? {20'h0, cmp_en}        :
      (araddr == OFS_CMP_SENSE) ? {20'h0, cmp_sense}     :
      (araddr == OFS_STATUS)    ? status                 :
      (araddr == OFS_FLAGS)     ? {20'h0, flags}         :
      rd_res                    ? {20'h0, results[rd_res ? rd_idx : 4'h0]} :
                                  32'h0000_0000;

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  AST_FRZ_NOW: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_now && (state == ST_SAMPLE) && !abort_req && !start_req
    |=> $stable(sample_cnt) && !convert_start && (state == ST_SAMPLE))
    else $error("Immediate freeze did not hold the sample phase.");

  AST_FRZ_FINISH: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_edge && !abort_req && !start_req
    |=> (state == ST_SAMPLE) && (sample_cnt == '0) && !sample_cnt[0])
    else $error("Finish-then-freeze started a new conversion.");

  AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_req |=> (state == ST_IDLE) && (cnt == 4'h0) && !convert_start)
    else $error("Register write did not abort the sequence.");

  AST_SAMPLE_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    convert_start |-> $past(sample_cnt) == SAMPLE_LEN[smp_sel] - 1'b1)
    else $error("Sample phase length does not match the select code.");

  AST_SEQ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_end && !fifo_mode |=> cnt == 4'h0)
    else $error("Counter not cleared at sequence end outside fifo mode.");

  AST_FIFO_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_end && fifo_mode && !abort_req && !start_req
    |=> cnt == 4'($past(cnt) + 1'b1))
    else $error("Counter reinitialised between sequences in fifo mode.");

  AST_START_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    start_req |=> (cnt == 4'h0) && (seq_pos == '0) && (state == ST_SAMPLE))
    else $error("New start did not clear the conversion counter.");

  AST_CMP_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_act && cmp_hit |=> flags[$past(pos_idx)])
    else $error("Successful compare did not set its match flag.");

  AST_NO_CMP: assert property (@(posedge aclk) disable iff (!aresetn)
    store && !wr_flags |=> (results[$past(cnt_idx)] == $past(result_data)) &&
                           (flags == $past(flags)))
    else $error("Uncompared conversion mishandled its result or flag.");

  AST_RUN_FREE: assert property (@(posedge aclk) disable iff (!aresetn)
    debug_freeze && !frz_sel[1] && (state == ST_SAMPLE) && !abort_req |-> ctl.run)
    else $error("Converter halted with freeze select code 00.");

endmodule : adc_sequence_timing_compare

// [bench/sar_model.sv]
// Behavioural successive-approximation machine on the far side of the sequencer.
// Assumes the sequencer's bus clock and reset; the bench sets answer delay and value.
`timescale 1ns/1ps
module sar_model
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Bench control.
  input  wire logic [7:0]       delay,
  input  wire logic [RES_W-1:0] value,
  // Sequencer side.
  input  wire logic             convert_start,
  output logic                  result_valid,
  output logic [RES_W-1:0]      result_data
);
  int left;

  // Between answers the data toggles, so a stale value never looks like a result.
  always @(posedge aclk) begin
    result_valid <= 1'h0;
    result_data  <= ~result_data;
    if (!aresetn) begin
      left        <= 0;
      result_data <= '0;
    end else if (convert_start) begin
      left <= int'(delay);
    end else if (left == 1) begin
      left         <= 0;
      result_valid <= 1'h1;
      result_data  <= value;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule : sar_model

// [bench/testbench.sv]
// Self-checking bench for the converter sequencer.
// Assumes the sequencer design files and the behavioural analog partner.
`timescale 1ns/1ps
module testbench
  import adc_ctrl_pkg::*;
;
  logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, debug_freeze;
  logic [7:0]       awaddr, araddr, sar_delay;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic [2:0]       awprot, arprot;
  logic [RES_W-1:0] sar_value;
  wire              awready, wready, bvalid, arready, rvalid;
  wire              sample_enable, convert_start, result_valid;
  wire  [1:0]       bresp, rresp;
  wire  [31:0]      rdata;
  wire  [RES_W-1:0] result_data;
  int               fail_count, total_checks, len, c;
  logic [31:0]      data;
  logic [1:0]       resp;
  logic [7:0]       abort_reg [2] = '{OFS_TIMING, OFS_CMP_EN};
  logic [1:0]       fz [3] = '{FRZ_RUN, FRZ_FINISH, FRZ_NOW};
  logic [31:0]      frz_stat [3] = '{32'h0, 32'h31, 32'h30};
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  row_t rows [12] = '{
    '{1'h0, OFS_TIMING, 32'h0, RESP_OKAY}, '{1'h0, OFS_CMP_EN, 32'h0, RESP_OKAY},
    '{1'h1, OFS_TIMING, 32'hE5, RESP_OKAY}, '{1'h0, OFS_TIMING, 32'hE5, RESP_OKAY},
    '{1'h1, OFS_CMP_EN, 32'hFFFF, RESP_OKAY}, '{1'h0, OFS_CMP_EN, 32'hFFF, RESP_OKAY},
    '{1'h1, OFS_CMP_SENSE, 32'hABC, RESP_OKAY}, '{1'h0, OFS_CMP_SENSE, 32'hABC, RESP_OKAY},
    '{1'h1, OFS_STATUS, 32'hF, RESP_OKAY}, '{1'h0, OFS_STATUS, 32'h0, RESP_OKAY},
    '{1'h1, 8'h30, 32'h5, RESP_SLVERR}, '{1'h0, 8'h30, 32'h0, RESP_SLVERR}};

  adc_sequence_timing_compare i_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .debug_freeze, .sample_enable,
    .convert_start, .result_valid, .result_data);
  sar_model i_sar (.aclk, .aresetn, .delay(sar_delay), .value(sar_value), .convert_start,
    .result_valid, .result_data);

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  // A wait that used up its bound is a hang; stop rather than cascade.
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      chk("wait bound", 32'h1, 32'h0);
      test_done();
    end
  endtask : bound

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while ((pa || pw) && n < 100) begin
      @(negedge aclk);
      if (awready === 1'h1) pa = 1'h0;
      if (wready === 1'h1) pw = 1'h0;
      @(posedge aclk);
      if (!pa) awvalid <= 1'h0;
      if (!pw) wvalid <= 1'h0;
      n++;
    end
    @(negedge aclk);
    while (bvalid !== 1'h1 && n < 100) begin @(negedge aclk); n++; end
    r = bresp;
    @(posedge aclk);
    bready <= 1'h0;
    @(posedge aclk);
    bound(n, 100);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(negedge aclk);
    while (arready !== 1'h1 && n < 100) begin @(negedge aclk); n++; end
    @(posedge aclk);
    arvalid <= 1'h0;
    @(negedge aclk);
    while (rvalid !== 1'h1 && n < 100) begin @(negedge aclk); n++; end
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
    @(posedge aclk);
    bound(n, 100);
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, e, d);
  endtask : rdchk

  task automatic count_cs(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin @(negedge aclk); if (convert_start === 1'h1) k++; end
    @(posedge aclk);
  endtask : count_cs

  task automatic wait_cs(input int k);
    int n, m;
    n = 0;
    m = 0;
    while (m < k && n < 1000) begin @(negedge aclk); if (convert_start === 1'h1) m++; n++; end
    @(posedge aclk);
    bound(n, 1000);
  endtask : wait_cs

  task automatic smp_len(output int l);
    int n;
    n = 0;
    l = 0;
    @(negedge aclk);
    while (sample_enable !== 1'h1 && n < 100) begin @(negedge aclk); n++; end
    while (sample_enable === 1'h1 && l < 400) begin l++; @(negedge aclk); end
    @(posedge aclk);
    bound(n, 100);
  endtask : smp_len

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, debug_freeze} = '0;
    {awaddr, araddr, wdata, awprot, arprot} = '0;
    wstrb = 4'hF;
    sar_delay = 8'h02;
    sar_value = 12'h200;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, resp);
      else axi_rd(rows[i].a, data, resp);
      if (!rows[i].wr) chk("read data", rows[i].d, data);
      chk("response", {30'h0, rows[i].r}, {30'h0, resp});
    end
    for (int s = 0; s < 8; s++) begin
      wr(OFS_TIMING, 32'((s << TIM_SMP) | (s % 3)));
      fork
        wr(OFS_CTRL, 32'h1);
        smp_len(len);
      join
      chk("sample length", 32'(SAMPLE_LEN[s]) * 2 * (s % 3 + 1), 32'(len));
    end
    sar_delay <= 8'h14;
    wr(8'h40, 32'h100);
    wr(8'h44, 32'h1FF);
    wr(OFS_CMP_SENSE, 32'h1);
    wr(OFS_FLAGS, 32'hFFF);
    wr(OFS_CMP_EN, 32'h3);
    wr(OFS_CTRL, 32'h201);
    wait_cs(2);
    rdchk("status mid sequence", OFS_STATUS, 32'h11);
    wait_cs(1);
    count_cs(40, c);
    chk("conversions after end", 32'h0, 32'(c));
    rdchk("status at end", OFS_STATUS, 32'h0);
    rdchk("match flags", OFS_FLAGS, 32'h1);
    rdchk("stored result", 8'h48, 32'h200);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, 32'h203);
      wait_cs(2);
      wr(abort_reg[i], 32'h0);
      rdchk("status after abort", OFS_STATUS, 32'h0);
    end
    sar_delay <= 8'h02;
    // Fifo and scan with one-conversion sequences: seventeen results wrap the counter to 1.
    wr(OFS_TIMING, 32'h0);
    wr(OFS_CTRL, 32'h7);
    wait_cs(18);
    rdchk("fifo counter after wrap", OFS_STATUS, 32'h11);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_TIMING, 32'h0);
      wr(OFS_CTRL, 32'h101 | (32'(fz[i]) << CTRL_FRZ));
      debug_freeze <= 1'h1;
      count_cs(300, c);
      chk("conversions in freeze", 32'(2 - i), 32'(c));
      rdchk("status in freeze", OFS_STATUS, frz_stat[i]);
      debug_freeze <= 1'h0;
    end
    test_done();
  end
endmodule : testbench
